// [rtl/power_mode_pkg.sv]
package power_mode_pkg;
	// opcode that the decoder takes as the halt instruction
	localparam logic [7:0]  HALT_OPCODE    = 8'h8e;
	// clock divide factors, counted in oscillator cycles
	localparam int          RUN_DIV        = 2;
	localparam int          SLOW_DIV       = 32;
	localparam int          DIV_W          = 5;
	localparam logic [4:0]  RUN_DIV_LAST   = 5'(RUN_DIV - 1);
	localparam logic [4:0]  SLOW_DIV_LAST  = 5'(SLOW_DIV - 1);
	// oscillator stabilisation delays in oscillator cycles
	localparam int          SHORT_STARTUP  = 256;
	localparam int          LONG_STARTUP   = 4096;
	localparam int          STARTUP_W      = 12;
	localparam logic [11:0] SHORT_LOAD     = 12'(SHORT_STARTUP - 1);
	localparam logic [11:0] LONG_LOAD      = 12'(LONG_STARTUP - 1);
	// interrupt sources, index 0 has the highest priority
	localparam int          IRQ_COUNT      = 14;
	localparam int          IRQ_W          = 4;
	// reset values
	localparam logic        MASK_RESET     = 1'b1;

	typedef enum logic [5:0] {
		MODE_RUN         = 6'h01,
		MODE_WAIT        = 6'h02,
		MODE_HALT        = 6'h04,
		MODE_ACTIVE_HALT = 6'h08,
		MODE_AWU_HALT    = 6'h10,
		MODE_STARTUP     = 6'h20
	} power_mode_t;
endpackage : power_mode_pkg

// [rtl/startup_delay_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module startup_delay_counter (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic start,
	input  wire logic longDelay,
	output var  logic busy,
	output var  logic done
);
	logic [power_mode_pkg::STARTUP_W-1:0] count;

	// loads on start, counts down, one-cycle done after the last count
	always_ff @(posedge clk) begin
		if (reset) begin
			busy  <= 1'b0;
			count <= '0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				busy  <= 1'b1;
				count <= longDelay ? power_mode_pkg::LONG_LOAD : power_mode_pkg::SHORT_LOAD;
			end else if (busy) begin
				if (count == '0) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					count <= count - 1'b1;
				end
			end
		end
	end
endmodule : startup_delay_counter
`default_nettype wire

// [rtl/power_mode_controller.sv]
//Function
// RULE1: slow select divides all clocks by 32
// RULE2: wait during slow gives slow-wait
// RULE3: wait stops cpu, peripherals keep clocking
// RULE4: wait entry clears interrupt mask only
// RULE5: wait ends on interrupt or reset vector
// RULE6: service pushes mask, sets, pop restores
// RULE7: plain halt needs no active-halt, no auto-wake
// RULE8: halt exit restarts oscillator, 256/4096 delay
// RULE9: halt entry forces interrupt mask zero
// RULE10: plain halt stops oscillator and all clocks
// RULE11: watchdog option makes halt a reset
// RULE12: opcode 8e decodes as halt
// RULE13: timer enables select active-halt
// RULE14: active-halt reset exit waits startup delay
// RULE15: active-halt interrupt exit resumes at once
// RULE16: active-halt entry clears interrupt mask
// RULE17: active-halt keeps oscillator and wake timer
// RULE18: active-halt never gives watchdog reset
// RULE19: only chosen interrupts leave active-halt
// RULE20: run mode clocks at oscillator over two
// RULE21: auto-wake enable selects auto-wake halt
// RULE22: per-source halt exit capability decides wake
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller (
	input  wire logic                                clk,
	input  wire logic                                reset,
	input  wire logic                                slowSelectBit,
	input  wire logic                                waitForInterruptInstr,
	input  wire logic                                opcodeValid,
	input  wire logic [7:0]                          opcode,
	input  wire logic                                timebaseOneIrqEnable,
	input  wire logic                                overflowIrqEnable,
	input  wire logic                                counterClockSelectLow,
	input  wire logic                                autoWakeEnable,
	input  wire logic                                watchdogHaltOption,
	input  wire logic                                watchdogEnabled,
	input  wire logic                                longStartup,
	input  wire logic                                resetWakeEvent,
	input  wire logic [power_mode_pkg::IRQ_COUNT-1:0] irqPending,
	input  wire logic [power_mode_pkg::IRQ_COUNT-1:0] irqHaltExit,
	input  wire logic [power_mode_pkg::IRQ_COUNT-1:0] irqActiveHaltExit,
	input  wire logic                                maskWrite,
	input  wire logic                                maskWriteValue,
	input  wire logic                                ccPop,
	output var  logic [5:0]                          powerMode,
	output var  logic                                slowActive,
	output var  logic                                cpuClkEnable,
	output var  logic                                periphClkEnable,
	output var  logic                                wakeTimerClkEnable,
	output var  logic                                oscEnable,
	output var  logic                                interruptMask,
	output var  logic                                ccPush,
	output var  logic [power_mode_pkg::IRQ_W-1:0]     vectorIndex,
	output var  logic                                resetVectorFetch,
	output var  logic                                watchdogReset
);
	power_mode_pkg::power_mode_t                state;
	logic [power_mode_pkg::DIV_W-1:0]           divCount;
	logic                                       divTick;
	logic [power_mode_pkg::IRQ_COUNT-1:0]       runReq;
	logic [power_mode_pkg::IRQ_COUNT-1:0]       haltReq;
	logic [power_mode_pkg::IRQ_COUNT-1:0]       activeReq;
	logic                                       haltInstr;
	logic                                       activeHaltSel;
	logic                                       wakeByReset;
	logic [power_mode_pkg::IRQ_W-1:0]           wakeIndex;
	logic                                       savedMask;
	logic                                       startDelay;
	logic                                       delayBusy;
	logic                                       delayDone;
	logic                                       serviceNow;
	logic                                       enterLowPower;
	logic [5:0]                                 slowAge;

	// lowest index among the requesting sources wins
	function automatic logic [power_mode_pkg::IRQ_W-1:0] firstSource(
		input logic [power_mode_pkg::IRQ_COUNT-1:0] req
	);
		logic [power_mode_pkg::IRQ_W-1:0] idx;
		idx = '0;
		for (int i = power_mode_pkg::IRQ_COUNT - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = power_mode_pkg::IRQ_W'(i);
			end
		end
		return idx;
	endfunction : firstSource

	// per-source request qualification for run, halt and active-halt
	generate
		for (genvar g = 0; g < power_mode_pkg::IRQ_COUNT; g++) begin : g_req
			assign runReq[g]    = irqPending[g] & ~interruptMask;
			assign haltReq[g]   = irqPending[g] & irqHaltExit[g];        // RULE22
			assign activeReq[g] = irqPending[g] & irqActiveHaltExit[g];  // RULE19
		end
	endgenerate

	// instruction decode and halt flavour selection
	assign haltInstr     = opcodeValid && (opcode == power_mode_pkg::HALT_OPCODE);          // RULE12
	assign activeHaltSel = timebaseOneIrqEnable | (overflowIrqEnable & counterClockSelectLow); // RULE13

	// free-running divider; the tick period follows the slow select bit
	always_ff @(posedge clk) begin
		if (reset) begin
			divCount <= '0;
		end else if (divTick) begin
			divCount <= '0;
		end else begin
			divCount <= divCount + 1'b1;
		end
	end
	assign divTick = slowSelectBit ? (divCount >= power_mode_pkg::SLOW_DIV_LAST)  // RULE1
	                               : (divCount >= power_mode_pkg::RUN_DIV_LAST);  // RULE20

	// cycles that slow mode has been held, saturating; lets the divider check ignore a mode change
	always_ff @(posedge clk) begin
		if (reset || !slowSelectBit) begin
			slowAge <= '0;
		end else if (slowAge != 6'h3f) begin
			slowAge <= slowAge + 1'b1;
		end
	end

	// oscillator stabilisation timer, shared by every halt exit that needs it
	startup_delay_counter u_startup (
		.clk       (clk),
		.reset     (reset),
		.start     (startDelay),
		.longDelay (longStartup),
		.busy      (delayBusy),
		.done      (delayDone)
	);

	// mode sequencer; service of an interrupt always returns to run
	always_ff @(posedge clk) begin
		if (reset) begin
			state            <= power_mode_pkg::MODE_RUN;   // RULE20
			wakeByReset      <= 1'b0;
			wakeIndex        <= '0;
			startDelay       <= 1'b0;
			ccPush           <= 1'b0;
			vectorIndex      <= '0;
			resetVectorFetch <= 1'b0;
			watchdogReset    <= 1'b0;
		end else begin
			startDelay       <= 1'b0;
			ccPush           <= 1'b0;
			resetVectorFetch <= 1'b0;
			watchdogReset    <= 1'b0;
			case (state)
				power_mode_pkg::MODE_RUN: begin
					if (haltInstr) begin
						if (activeHaltSel) begin
							state <= power_mode_pkg::MODE_ACTIVE_HALT; // RULE18
						end else if (watchdogEnabled && watchdogHaltOption) begin
							watchdogReset <= 1'b1;                     // RULE11
						end else if (autoWakeEnable) begin
							state <= power_mode_pkg::MODE_AWU_HALT;    // RULE21
						end else begin
							state <= power_mode_pkg::MODE_HALT;        // RULE7
						end
					end else if (waitForInterruptInstr) begin
						state <= power_mode_pkg::MODE_WAIT;            // RULE3
					end else if (|runReq) begin
						ccPush      <= 1'b1;
						vectorIndex <= firstSource(runReq);
					end
				end
				power_mode_pkg::MODE_WAIT: begin
					if (resetWakeEvent) begin
						state            <= power_mode_pkg::MODE_RUN;
						resetVectorFetch <= 1'b1;                      // RULE5
					end else if (|irqPending) begin
						state       <= power_mode_pkg::MODE_RUN;
						ccPush      <= 1'b1;                           // RULE5
						vectorIndex <= firstSource(irqPending);
					end
				end
				power_mode_pkg::MODE_HALT,
				power_mode_pkg::MODE_AWU_HALT: begin
					if (resetWakeEvent || (|haltReq)) begin
						state       <= power_mode_pkg::MODE_STARTUP;   // RULE8
						startDelay  <= 1'b1;
						wakeByReset <= resetWakeEvent;
						wakeIndex   <= firstSource(haltReq);
					end
				end
				power_mode_pkg::MODE_ACTIVE_HALT: begin
					if (resetWakeEvent) begin
						state       <= power_mode_pkg::MODE_STARTUP;   // RULE14
						startDelay  <= 1'b1;
						wakeByReset <= 1'b1;
					end else if (|activeReq) begin
						state       <= power_mode_pkg::MODE_RUN;       // RULE15
						ccPush      <= 1'b1;
						vectorIndex <= firstSource(activeReq);
					end
				end
				power_mode_pkg::MODE_STARTUP: begin
					if (delayDone) begin
						state <= power_mode_pkg::MODE_RUN;
						if (wakeByReset) begin
							resetVectorFetch <= 1'b1;                  // RULE8
						end else begin
							ccPush      <= 1'b1;                       // RULE8
							vectorIndex <= wakeIndex;
						end
					end
				end
				default: begin
					state <= power_mode_pkg::MODE_RUN;
				end
			endcase
		end
	end

	// the mask service event is the pushed service pulse itself, in the same cycle
	assign serviceNow    = ccPush;
	assign enterLowPower = (state == power_mode_pkg::MODE_RUN) &&
	                       ((haltInstr && !(watchdogEnabled && watchdogHaltOption && !activeHaltSel)) ||
	                        (!haltInstr && waitForInterruptInstr));

	// interrupt mask: service entry sets and wins, low-power entry clears
	always_ff @(posedge clk) begin
		if (reset) begin
			interruptMask <= power_mode_pkg::MASK_RESET;
			savedMask     <= power_mode_pkg::MASK_RESET;
		end else begin
			if (serviceNow) begin
				savedMask     <= interruptMask;                       // RULE6
				interruptMask <= 1'b1;                                // RULE6
			end else if (enterLowPower) begin
				interruptMask <= 1'b0;                                // RULE4 RULE9 RULE16
			end else if (ccPop) begin
				interruptMask <= savedMask;                           // RULE6
			end else if (maskWrite) begin
				interruptMask <= maskWriteValue;
			end
		end
	end

	// clock gating: only run clocks the cpu; wait keeps peripherals going;
	// active-halt keeps just the oscillator and the selected wake timer
	always_ff @(posedge clk) begin
		if (reset) begin
			cpuClkEnable       <= 1'b0;
			periphClkEnable    <= 1'b0;
			wakeTimerClkEnable <= 1'b0;
			oscEnable          <= 1'b1;
			slowActive         <= 1'b0;
			powerMode          <= power_mode_pkg::MODE_RUN;
		end else begin
			cpuClkEnable       <= divTick && (state == power_mode_pkg::MODE_RUN);              // RULE3
			periphClkEnable    <= divTick && ((state == power_mode_pkg::MODE_RUN) ||
			                                  (state == power_mode_pkg::MODE_WAIT));         // RULE2
			wakeTimerClkEnable <= divTick && ((state == power_mode_pkg::MODE_RUN) ||
			                                  (state == power_mode_pkg::MODE_WAIT) ||
			                                  (state == power_mode_pkg::MODE_ACTIVE_HALT));  // RULE17
			oscEnable          <= (state != power_mode_pkg::MODE_HALT) &&
			                      (state != power_mode_pkg::MODE_AWU_HALT);                  // RULE10
			slowActive         <= slowSelectBit;
			powerMode          <= state;
		end
	end

	// checks

	a_halt_opcode_entry: assert property (@(posedge clk) disable iff (reset) // RULE7 RULE12
		(state == power_mode_pkg::MODE_RUN) && opcodeValid && (opcode == power_mode_pkg::HALT_OPCODE) &&
		!activeHaltSel && !autoWakeEnable && !(watchdogEnabled && watchdogHaltOption)
		|=> state == power_mode_pkg::MODE_HALT) else $error("halt opcode did not enter halt");

	a_active_halt_select: assert property (@(posedge clk) disable iff (reset) // RULE13 RULE18
		(state == power_mode_pkg::MODE_RUN) && haltInstr && activeHaltSel
		|=> (state == power_mode_pkg::MODE_ACTIVE_HALT) && !watchdogReset)
		else $error("active-halt not selected or watchdog fired");

	a_watchdog_halt_reset: assert property (@(posedge clk) disable iff (reset) // RULE11
		(state == power_mode_pkg::MODE_RUN) && haltInstr && !activeHaltSel && watchdogEnabled && watchdogHaltOption
		|=> watchdogReset && (state == power_mode_pkg::MODE_RUN)) else $error("watchdog halt reset missing");

	// a service pulse in the entry cycle legitimately wins over the clear
	a_mask_cleared_entry: assert property (@(posedge clk) disable iff (reset) // RULE4 RULE9 RULE16
		($past(state) == power_mode_pkg::MODE_RUN) && (state != power_mode_pkg::MODE_RUN) && !$past(ccPush)
		|-> !interruptMask) else $error("mask not cleared on low-power entry");

	a_halt_osc_off: assert property (@(posedge clk) disable iff (reset) // RULE10
		(state == power_mode_pkg::MODE_HALT) ##1 (state == power_mode_pkg::MODE_HALT)
		|-> !oscEnable && !cpuClkEnable && !periphClkEnable) else $error("clocks running in halt");

	a_wait_cpu_stopped: assert property (@(posedge clk) disable iff (reset) // RULE3
		(state == power_mode_pkg::MODE_WAIT) |=> !cpuClkEnable) else $error("cpu clocked in wait");

	// load cycle plus 256 counts plus the done cycle, then the service or fetch pulse
	a_startup_short_delay: assert property (@(posedge clk) disable iff (reset) // RULE8 RULE14
		startDelay && !longStartup |-> ##257 (state == power_mode_pkg::MODE_STARTUP) ##1
		((state == power_mode_pkg::MODE_RUN) && (resetVectorFetch || ccPush)))
		else $error("short startup delay wrong");

	a_startup_busy: assert property (@(posedge clk) disable iff (reset) // RULE8 RULE14
		(state == power_mode_pkg::MODE_STARTUP) && !startDelay |-> delayBusy || delayDone)
		else $error("startup timer idle during startup");

	a_active_irq_immediate: assert property (@(posedge clk) disable iff (reset) // RULE15 RULE19
		(state == power_mode_pkg::MODE_ACTIVE_HALT) && !resetWakeEvent && (|activeReq)
		|=> ccPush && (vectorIndex == firstSource($past(activeReq))) && (state == power_mode_pkg::MODE_RUN))
		else $error("active-halt interrupt exit not immediate");

	a_service_sets_mask: assert property (@(posedge clk) disable iff (reset) // RULE6
		ccPush |=> interruptMask && (savedMask == $past(interruptMask)))
		else $error("service entry did not set mask");

	// a tick in slow mode is followed by the next one 32 cycles on, unless slow was dropped meanwhile
	a_slow_divider: assert property (@(posedge clk) disable iff (reset) // RULE1
		slowSelectBit && divTick |-> ##32 (divTick || (slowAge < 6'h20)))
		else $error("slow divider period wrong");
endmodule : power_mode_controller
`default_nettype wire

// [verif/core_irq_model.sv]
`timescale 1ns/1ps
`default_nettype none
// stands in for the cpu core and the interrupt controller around the mode controller
module core_irq_model #(
	parameter int POP_DELAY = 6
) (
	input  wire logic                                  clk,
	input  wire logic                                  reset,
	input  wire logic [power_mode_pkg::IRQ_COUNT-1:0]  raise,
	input  wire logic [power_mode_pkg::IRQ_COUNT-1:0]  drop,
	input  wire logic                                  ccPush,
	input  wire logic [power_mode_pkg::IRQ_W-1:0]      vectorIndex,
	output wire logic [power_mode_pkg::IRQ_COUNT-1:0]  irqPending,
	output wire logic                                  ccPop
);
	logic [power_mode_pkg::IRQ_COUNT-1:0] latched;
	logic [power_mode_pkg::IRQ_COUNT-1:0] ack;
	int                                   popCount;

	// acknowledged in the vector cycle itself, so one request is never serviced twice
	assign ack        = {{(power_mode_pkg::IRQ_COUNT-1){1'b0}}, ccPush} << vectorIndex;
	assign irqPending = latched & ~ack;
	assign ccPop      = (popCount == 1);

	// requests stay pending until serviced or withdrawn by the bench
	always_ff @(posedge clk) begin
		if (reset)
			latched <= '0;
		else
			latched <= (latched | raise) & ~drop & ~ack;
	end

	// a short service routine that ends by popping the condition code
	always_ff @(posedge clk) begin
		if (reset || ccPush)
			popCount <= ccPush ? POP_DELAY : 0;
		else if (popCount > 0)
			popCount <= popCount - 1;
	end
endmodule : core_irq_model
`default_nettype wire

// [verif/test_power_mode_controller.sv]
`timescale 1ns/1ps
`default_nettype none
module test_power_mode_controller;
	localparam int N = power_mode_pkg::IRQ_COUNT;
	logic         clk = 1'b0, reset = 1'b1, slowSelectBit = 1'b0, waitForInterruptInstr = 1'b0;
	logic         opcodeValid = 1'b0, timebaseOneIrqEnable = 1'b0, overflowIrqEnable = 1'b0;
	logic         counterClockSelectLow = 1'b0, autoWakeEnable = 1'b0, watchdogHaltOption = 1'b0;
	logic         watchdogEnabled = 1'b0, longStartup = 1'b0, resetWakeEvent = 1'b0;
	logic         maskWrite = 1'b0, maskWriteValue = 1'b0, clearCounts = 1'b0;
	logic [7:0]   opcode = 8'h00;
	logic [N-1:0] irqHaltExit = 14'h1005, irqActiveHaltExit = 14'h0a00, raise = '0, drop = '0;
	logic [N-1:0] irqPending;
	logic [5:0]   powerMode;
	logic [3:0]   vectorIndex;
	logic         ccPop, slowActive, cpuClkEnable, periphClkEnable, wakeTimerClkEnable, oscEnable;
	logic         interruptMask, ccPush, resetVectorFetch, watchdogReset;
	int           nCpu = 0, nPer = 0, nWake = 0, nWdg = 0, failCount = 0, numChecks = 0;

	// 200 MHz oscillator clock
	always #2.5 clk = ~clk;

	// pulse counters for the clock enables and the watchdog request
	always @(posedge clk) begin
		nCpu  <= (clearCounts ? 0 : nCpu) + int'(cpuClkEnable === 1'b1);
		nPer  <= (clearCounts ? 0 : nPer) + int'(periphClkEnable === 1'b1);
		nWake <= (clearCounts ? 0 : nWake) + int'(wakeTimerClkEnable === 1'b1);
		nWdg  <= nWdg + int'(watchdogReset === 1'b1);
	end

	power_mode_controller power_mode_controller_i (.clk(clk), .reset(reset), .slowSelectBit(slowSelectBit),
		.waitForInterruptInstr(waitForInterruptInstr), .opcodeValid(opcodeValid), .opcode(opcode),
		.timebaseOneIrqEnable(timebaseOneIrqEnable), .overflowIrqEnable(overflowIrqEnable),
		.counterClockSelectLow(counterClockSelectLow), .autoWakeEnable(autoWakeEnable),
		.watchdogHaltOption(watchdogHaltOption), .watchdogEnabled(watchdogEnabled), .longStartup(longStartup),
		.resetWakeEvent(resetWakeEvent), .irqPending(irqPending), .irqHaltExit(irqHaltExit),
		.irqActiveHaltExit(irqActiveHaltExit), .maskWrite(maskWrite), .maskWriteValue(maskWriteValue),
		.ccPop(ccPop), .powerMode(powerMode), .slowActive(slowActive), .cpuClkEnable(cpuClkEnable),
		.periphClkEnable(periphClkEnable), .wakeTimerClkEnable(wakeTimerClkEnable), .oscEnable(oscEnable),
		.interruptMask(interruptMask), .ccPush(ccPush), .vectorIndex(vectorIndex),
		.resetVectorFetch(resetVectorFetch), .watchdogReset(watchdogReset));

	core_irq_model core_irq_model_i (.clk(clk), .reset(reset), .raise(raise), .drop(drop), .ccPush(ccPush),
		.vectorIndex(vectorIndex), .irqPending(irqPending), .ccPop(ccPop));

	// inputs move 1 ns after the rising edge, except raise and drop, which irq clears on the edge itself
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		numChecks++;
		if (seen !== exp) begin
			failCount++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// a window spanning whole divider periods so the pulse count is exact
	// the counters restart at the first edge, so they keep a single driver
	task automatic window(input int n);
		clearCounts = 1'b1;
		step(1);
		clearCounts = 1'b0;
		step(n - 1);
	endtask : window

	// one decoded opcode, then room for the mode output to follow
	task automatic send_opcode(input logic [7:0] code);
		opcode = code;
		opcodeValid = 1'b1;
		step(1);
		opcodeValid = 1'b0;
		step(4);
	endtask : send_opcode

	task automatic irq(input int idx, input bit withdraw);
		if (withdraw)
			drop[idx] = 1'b1;
		else
			raise[idx] = 1'b1;
		// cleared on the sampling edge so a following call never writes them twice in one step
		@(posedge clk);
		raise <= '0;
		drop <= '0;
		#1;
	endtask : irq

	// edges until the vector or reset fetch, judged against a window
	task automatic latency(input bit useReset, input int lo, input int hi, input string name);
		int n;
		n = 0;
		while ((useReset ? resetVectorFetch : ccPush) !== 1'b1 && n < hi + 2) begin
			step(1);
			n++;
		end
		check(name, 16'(n >= lo && n <= hi), 16'h0001);
	endtask : latency

	task automatic results;
		$display("checks %0d mismatches %0d", numChecks, failCount);
		if (failCount == 0 && numChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	// a hang past about six times the expected run time ends the test
	initial begin
		#200000;
		failCount++;
		results();
	end

	initial begin
		step(12);
		reset = 1'b0;
		step(2);
		check("modeAfterReset", 16'(powerMode), 16'h0001);
		check("oscAfterReset", 16'(oscEnable), 16'h0001);
		window(320);
		check("runCpuRate", 16'(nCpu), 16'(320 / power_mode_pkg::RUN_DIV));
		check("runPerRate", 16'(nPer), 16'(320 / power_mode_pkg::RUN_DIV));
		// slow mode, then wait entered from it
		slowSelectBit = 1'b1;
		step(40);
		window(320);
		check("slowCpuRate", 16'(nCpu), 16'(320 / power_mode_pkg::SLOW_DIV));
		check("slowPerRate", 16'(nPer), 16'(320 / power_mode_pkg::SLOW_DIV));
		waitForInterruptInstr = 1'b1;
		step(1);
		waitForInterruptInstr = 1'b0;
		step(4);
		check("waitMode", 16'(powerMode), 16'h0002);
		check("slowWait", 16'(slowActive), 16'h0001);
		check("waitMask", 16'(interruptMask), 16'h0000);
		window(320);
		check("waitCpu", 16'(nCpu), 16'h0000);
		check("slowWaitPer", 16'(nPer), 16'(320 / power_mode_pkg::SLOW_DIV));
		irq(5, 1'b0);
		latency(1'b0, 1, 3, "waitWake");
		check("waitVector", 16'(vectorIndex), 16'h0005);
		step(1);
		check("serviceMask", 16'(interruptMask), 16'h0001);
		step(10);
		check("popMask", 16'(interruptMask), 16'h0000);
		check("waitExitMode", 16'(powerMode), 16'h0001);
		slowSelectBit = 1'b0;
		maskWriteValue = 1'b1;
		maskWrite = 1'b1;
		step(1);
		maskWrite = 1'b0;
		step(2);
		check("maskWrite", 16'(interruptMask), 16'h0001);
		// plain halt, watchdog on but its option clear, both startup lengths
		watchdogEnabled = 1'b1;
		send_opcode(8'h8f);
		check("notHalt", 16'(powerMode), 16'h0001);
		for (int i = 0; i < 2; i++) begin
			longStartup = i[0];
			send_opcode(power_mode_pkg::HALT_OPCODE);
			check("haltMode", 16'(powerMode), 16'h0004);
			check("haltMask", 16'(interruptMask), 16'h0000);
			check("haltOsc", 16'(oscEnable), 16'h0000);
			window(64);
			check("haltClocks", 16'(nCpu + nPer + nWake), 16'h0000);
			irq(11, 1'b0);
			step(8);
			check("haltIgnores", 16'(powerMode), 16'h0004);
			irq(11, 1'b1);
			irq(2, 1'b0);
			latency(1'b0, (i ? 4096 : 256) + 1, (i ? 4096 : 256) + 6, "haltWake");
			check("haltVector", 16'(vectorIndex), 16'h0002);
			step(12);
			check("oscRestart", 16'(oscEnable), 16'h0001);
		end
		// watchdog option turns halt into a watchdog reset, but not active-halt
		watchdogHaltOption = 1'b1;
		longStartup = 1'b0;
		send_opcode(power_mode_pkg::HALT_OPCODE);
		check("wdgReset", 16'(nWdg), 16'h0001);
		check("wdgStaysRun", 16'(powerMode), 16'h0001);
		timebaseOneIrqEnable = 1'b1;
		send_opcode(power_mode_pkg::HALT_OPCODE);
		check("activeHalt", 16'(powerMode), 16'h0008);
		check("activeNoWdg", 16'(nWdg), 16'h0001);
		check("activeMask", 16'(interruptMask), 16'h0000);
		check("activeOsc", 16'(oscEnable), 16'h0001);
		window(320);
		check("activeWake", 16'(nWake), 16'(320 / power_mode_pkg::RUN_DIV));
		check("activePer", 16'(nPer + nCpu), 16'h0000);
		irq(2, 1'b0);
		step(8);
		check("activeIgnores", 16'(powerMode), 16'h0008);
		irq(2, 1'b1);
		irq(11, 1'b0);
		latency(1'b0, 1, 3, "activeIrqWake");
		check("activeVector", 16'(vectorIndex), 16'h000b);
		step(12);
		// second active-halt selection, left by reset
		timebaseOneIrqEnable = 1'b0;
		overflowIrqEnable = 1'b1;
		counterClockSelectLow = 1'b1;
		send_opcode(power_mode_pkg::HALT_OPCODE);
		check("activeByOvf", 16'(powerMode), 16'h0008);
		resetWakeEvent = 1'b1;
		step(1);
		resetWakeEvent = 1'b0;
		latency(1'b1, 257, 262, "activeResetWake");
		step(4);
		check("resetExitRun", 16'(powerMode), 16'h0001);
		// auto-wake halt
		overflowIrqEnable = 1'b0;
		watchdogEnabled = 1'b0;
		autoWakeEnable = 1'b1;
		send_opcode(power_mode_pkg::HALT_OPCODE);
		check("autoWakeMode", 16'(powerMode), 16'h0010);
		check("autoWakeOsc", 16'(oscEnable), 16'h0000);
		irq(0, 1'b0);
		latency(1'b0, 257, 262, "autoWake");
		step(12);
		results();
	end
endmodule : test_power_mode_controller
`default_nettype wire
